//--- rtl/fdx_cfg.svh
// Offsets, field positions, reset values and timing counts of the seek/perpendicular/lock block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and a 10 MHz system clock.
`ifndef FDX_CFG_SVH
`define FDX_CFG_SVH
`define FDX_A_CMD     6'h00
`define FDX_A_PERP    6'h04
`define FDX_A_LOCK    6'h08
`define FDX_A_CONF    6'h0C
`define FDX_A_STAT    6'h10
`define FDX_A_SRST    6'h14
`define FDX_A_DUMP8   6'h18
`define FDX_A_MODE    6'h1C
`define FDX_A_TIME    6'h20
`define FDX_CMD_DIR   8
`define FDX_CMD_DRV   10
`define FDX_CMD_KIND  12
`define FDX_PERP_PERM 7
`define FDX_CONF_THR  1
`define FDX_CONF_PRE  8
`define FDX_CONF_R1M  16
`define FDX_CONF_SEL  17
`define FDX_QDIS_RST  1'b1
`define FDX_THR_RST   4'h0
`define FDX_PRE_RST   8'h00
`define FDX_ST0_FAULT 4
`define FDX_RECAL_MAX 8'h50
`define FDX_GAP2_1M   8'h29
`define FDX_GAP2_STD  8'h16
`define FDX_VCO_1M    8'h2B
`define FDX_VCO_STD   8'h18
`define FDX_WG_1M     8'h26
`define FDX_WG_500K   8'h13
`define FDX_CLK_HZ    10000000
`define FDX_STEP_NS   3000
`define FDX_PULSE_NS  1000
`define FDX_STEP_CYC  ((`FDX_STEP_NS * (`FDX_CLK_HZ / 1000000) + 999) / 1000)
`define FDX_PULSE_CYC ((`FDX_PULSE_NS * (`FDX_CLK_HZ / 1000000) + 999) / 1000)
`endif

//--- rtl/fdx_pkg.sv
// Types shared by the seek/perpendicular/lock block.
// Assumes nothing beyond a SystemVerilog compiler.
package fdx_pkg;
    typedef enum logic [1:0] {FDX_SEEK, FDX_RELSEEK, FDX_RECAL, FDX_NONE} fdx_kind_e;
    typedef enum logic [1:0] {FDX_COMPAT_A, FDX_COMPAT_B, FDX_COMPAT_C} fdx_regmode_e;
    typedef logic [7:0] fdx_cyl_t;
endpackage : fdx_pkg

//--- rtl/fdx_core.sv
// Seek engines, perpendicular mode settings and lock protection of a floppy controller.
// Assumes an Avalon-MM master on CLK_I and drive home-track pins from outside the clock domain.
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "fdx_cfg.svh"
module fdx_core #(
    parameter int STEP_CYC  = `FDX_STEP_CYC,
    parameter int PULSE_CYC = `FDX_PULSE_CYC
) (
    // Clock, reset and enable.
    input  wire logic              CLK_I,
    input  wire logic              RST_B_I,
    input  wire logic              CE_I,
    // Avalon-MM slave.
    input  wire logic [5:0]        AVS_ADDRESS_I,
    input  wire logic              AVS_READ_I,
    input  wire logic              AVS_WRITE_I,
    input  wire logic [31:0]       AVS_WRITEDATA_I,
    output logic      [31:0]       AVS_READDATA_O,
    output logic                   AVS_WAITREQUEST_O,
    // Drive interface.
    input  wire logic [3:0]        HOME_TRACK_SENSE_I,
    output logic      [3:0]        STEP_O,
    output logic      [3:0]        DIR_O,
    // Register mode seen by the rest of the controller.
    output fdx_pkg::fdx_regmode_e  REG_MODE_O
);
    import fdx_pkg::*;

    // Home sense needs five cycles back through the synchroniser before the next step decision.
    if (STEP_CYC < 5 || PULSE_CYC < 1 || PULSE_CYC >= STEP_CYC || STEP_CYC > 65535)
    begin : g_bad_timing
        $error("fdx_core: bad step timing");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave.

    logic        ack;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] rd_next;
    logic        soft_rst;

    // One wait cycle; the request completes on the edge where ack is high.
    assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack;
    assign wr_go    = CE_I & AVS_WRITE_I & ack;
    assign rd_go    = CE_I & AVS_READ_I & ack;
    assign soft_rst = wr_go && AVS_ADDRESS_I == `FDX_A_SRST;

    // Acknowledge flop.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
            ack <= 1'b0;
        else if (CE_I)
            ack <= (AVS_READ_I | AVS_WRITE_I) & ~ack;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Perpendicular, lock and configuration state.

    logic       gap;
    logic       write_timing_select;
    logic [3:0] pflags;
    logic       lock;
    logic       qdis;
    logic [3:0] thr;
    logic [7:0] pre;
    logic       rate_1m;
    logic [1:0] sel;
    logic [2:0] mode_bits;

    // Global bits: hardware and software reset clear them.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
            {write_timing_select, gap} <= 2'h0;
        else if (CE_I && soft_rst)
            {write_timing_select, gap} <= 2'h0;
        else if (wr_go && AVS_ADDRESS_I == `FDX_A_PERP)
            {write_timing_select, gap} <= AVS_WRITEDATA_I[1:0];
    end

    // Per-drive flags survive software reset and need the write permit.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
            pflags <= 4'h0;
        else if (wr_go && AVS_ADDRESS_I == `FDX_A_PERP && AVS_WRITEDATA_I[`FDX_PERP_PERM])
            pflags <= AVS_WRITEDATA_I[5:2];
    end

    // Lock bit, cleared by hardware reset or by a LOCK write with bit 7 low; software reset keeps it.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
            lock <= 1'b0;
        else if (wr_go && AVS_ADDRESS_I == `FDX_A_LOCK)
            lock <= AVS_WRITEDATA_I[7];
    end

    // Queue and precompensation settings; software reset restores them unless locked.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            qdis <= `FDX_QDIS_RST;
            thr  <= `FDX_THR_RST;
            pre  <= `FDX_PRE_RST;
        end
        else if (CE_I && soft_rst && !lock)
        begin
            qdis <= `FDX_QDIS_RST;
            thr  <= `FDX_THR_RST;
            pre  <= `FDX_PRE_RST;
        end
        else if (wr_go && AVS_ADDRESS_I == `FDX_A_CONF)
        begin
            qdis <= AVS_WRITEDATA_I[0];
            thr  <= AVS_WRITEDATA_I[`FDX_CONF_THR +: 4];
            pre  <= AVS_WRITEDATA_I[`FDX_CONF_PRE +: 8];
        end
    end

    // Data rate choice and drive selector for the timing view; mode straps.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            rate_1m   <= 1'b0;
            sel       <= 2'h0;
            mode_bits <= 3'h0;
        end
        else if (wr_go && AVS_ADDRESS_I == `FDX_A_CONF)
        begin
            rate_1m <= AVS_WRITEDATA_I[`FDX_CONF_R1M];
            sel     <= AVS_WRITEDATA_I[`FDX_CONF_SEL +: 2];
        end
        else if (wr_go && AVS_ADDRESS_I == `FDX_A_MODE)
            mode_bits <= AVS_WRITEDATA_I[2:0];
    end

    // Platform select in bit 1 (bit 0 is not decoded), double density encoding in bit 2.
    always_comb
    begin
        if (mode_bits[1])
            REG_MODE_O = mode_bits[2] ? FDX_COMPAT_C : FDX_COMPAT_B;
        else
            REG_MODE_O = FDX_COMPAT_A;
    end

    // Effective mode of a drive: {perpendicular, 1 Mbps}.
    function automatic logic [1:0] perp_of(input logic [1:0] d);
        logic [1:0] m;
        m = 2'h0;
        if (write_timing_select && gap)
            m = 2'b11;
        else if (gap && !write_timing_select)
            m = 2'b10;
        else if (!gap && !write_timing_select && pflags[d])
            m = {1'b1, rate_1m};
        return m;
    endfunction : perp_of

    logic [1:0] pm;
    logic [7:0] gap2_len;
    logic [7:0] vco_at;
    logic [7:0] wg_bytes;
    logic       pre_on;

    // Gap2, VCO start and write gate figures for the selected drive.
    always_comb
    begin
        pm       = perp_of(sel);
        gap2_len = (pm == 2'b11) ? `FDX_GAP2_1M : `FDX_GAP2_STD;
        vco_at   = (pm == 2'b11) ? `FDX_VCO_1M : `FDX_VCO_STD;
        wg_bytes = pm[1] ? (pm[0] ? `FDX_WG_1M : `FDX_WG_500K) : 8'h00;
        pre_on   = !(pflags[sel] && !gap && !write_timing_select);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Seek engines, one per drive.

    logic [1:0]  h1 [4];
    logic [3:0]  h2;
    fdx_kind_e   kind [4];
    logic [3:0]  act;
    logic [3:0]  dirr;
    fdx_cyl_t    cnt [4];
    fdx_cyl_t    pc [4];
    logic [15:0] tmr [4];
    logic [7:0]  st0;
    logic        end_pend;
    logic        cmd_go;
    logic [1:0]  c_drv;
    fdx_kind_e   c_kind;
    logic        c_ok;
    logic [3:0]  step_now;

    // Home track pins pass three flops.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            for (int i = 0; i < 4; i++)
                h1[i] <= 2'h0;
            h2 <= 4'h0;
        end
        else if (CE_I)
        begin
            for (int i = 0; i < 4; i++)
                h1[i] <= {h1[i][0], HOME_TRACK_SENSE_I[i]};
            for (int i = 0; i < 4; i++)
                h2[i] <= h1[i][1];
        end
    end

    // Command decode: relative seek shares the seek layout.
    assign cmd_go = wr_go && AVS_ADDRESS_I == `FDX_A_CMD;
    assign c_drv  = AVS_WRITEDATA_I[`FDX_CMD_DRV +: 2];
    assign c_kind = fdx_kind_e'(AVS_WRITEDATA_I[`FDX_CMD_KIND +: 2]);
    assign c_ok   = cmd_go && c_kind != FDX_NONE && !act[c_drv]
                    && !(c_kind == FDX_RELSEEK && |(act & rel_mask()));

    function automatic logic [3:0] rel_mask();
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++)
            m[i] = kind[i] == FDX_RELSEEK;
        return m;
    endfunction : rel_mask

    // Step engines; each engine acts when its interval timer expires.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            act      <= 4'h0;
            dirr     <= 4'h0;
            STEP_O   <= 4'h0;
            st0      <= 8'h00;
            end_pend <= 1'b0;
            step_now <= 4'h0;
            for (int i = 0; i < 4; i++)
            begin
                kind[i] <= FDX_NONE;
                cnt[i]  <= 8'h00;
                pc[i]   <= 8'h00;
                tmr[i]  <= 16'h0000;
            end
        end
        else if (CE_I)
        begin
            step_now <= 4'h0;
            if (rd_go && AVS_ADDRESS_I == `FDX_A_STAT)
                end_pend <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                if (tmr[i] == 16'(STEP_CYC - PULSE_CYC))
                    STEP_O[i] <= 1'b0;
                if (c_ok && c_drv == 2'(i))
                begin
                    act[i]  <= 1'b1;
                    kind[i] <= c_kind;
                    tmr[i]  <= 16'h0000;
                    dirr[i] <= AVS_WRITEDATA_I[`FDX_CMD_DIR];
                    cnt[i]  <= (c_kind == FDX_RECAL) ? 8'h00 : AVS_WRITEDATA_I[7:0];
                    if (c_kind == FDX_RECAL)
                        pc[i] <= 8'h00;
                end
                else if (act[i] && tmr[i] != 16'h0000)
                    tmr[i] <= tmr[i] - 16'h0001;
                else if (act[i])
                begin
                    tmr[i] <= 16'(STEP_CYC - 1);
                    case (kind[i])
                        FDX_RELSEEK:
                        begin
                            if (cnt[i] == 8'h00 || (!dirr[i] && h2[i]))
                            begin
                                act[i]   <= 1'b0;
                                kind[i]  <= FDX_NONE;
                                end_pend <= 1'b1;
                                st0      <= {1'b0, cnt[i] != 8'h00, 1'b1, cnt[i] != 8'h00, 2'h0, 2'(i)};
                            end
                            else
                            begin
                                STEP_O[i]   <= 1'b1;
                                step_now[i] <= 1'b1;
                                cnt[i]      <= cnt[i] - 8'h01;
                                pc[i]       <= dirr[i] ? pc[i] + 8'h01 : pc[i] - 8'h01;
                            end
                        end
                        FDX_SEEK:
                        begin
                            if (pc[i] == cnt[i])
                            begin
                                act[i]   <= 1'b0;
                                kind[i]  <= FDX_NONE;
                                end_pend <= 1'b1;
                                st0      <= {3'b001, 3'h0, 2'(i)};
                            end
                            else
                            begin
                                dirr[i]     <= cnt[i] > pc[i];
                                STEP_O[i]   <= 1'b1;
                                step_now[i] <= 1'b1;
                                pc[i]       <= (cnt[i] > pc[i]) ? pc[i] + 8'h01 : pc[i] - 8'h01;
                            end
                        end
                        FDX_RECAL:
                        begin
                            dirr[i] <= 1'b0;
                            if (h2[i] || cnt[i] == `FDX_RECAL_MAX)
                            begin
                                act[i]   <= 1'b0;
                                kind[i]  <= FDX_NONE;
                                end_pend <= 1'b1;
                                st0      <= {1'b0, !h2[i], 1'b1, !h2[i], 2'h0, 2'(i)};
                            end
                            else
                            begin
                                STEP_O[i]   <= 1'b1;
                                step_now[i] <= 1'b1;
                                cnt[i]      <= cnt[i] + 8'h01;
                            end
                        end
                        default:
                            act[i] <= 1'b0;
                    endcase
                end
            end
        end
    end

    assign DIR_O = dirr;

    ////////////////////////////////////////////////////////////////////////////////
    // Read data.

    // Read value is captured in the wait cycle and stands at the completing edge.
    always_comb
    begin
        case (AVS_ADDRESS_I)
            `FDX_A_CMD:   rd_next = {24'h0, 4'h0, act};
            `FDX_A_PERP:  rd_next = {26'h0, pflags, write_timing_select, gap};
            `FDX_A_LOCK:  rd_next = {27'h0, lock, 4'h0};
            `FDX_A_CONF:  rd_next = {13'h0, sel, rate_1m, pre, 3'h0, thr, qdis};
            `FDX_A_STAT:  rd_next = {15'h0, end_pend, pc[st0[1:0]], st0};
            `FDX_A_DUMP8: rd_next = {24'h0, lock, 1'b0, pflags, gap, write_timing_select};
            `FDX_A_MODE:  rd_next = {29'h0, mode_bits};
            `FDX_A_TIME:  rd_next = {7'h0, pre_on, wg_bytes, vco_at, gap2_len};
            default:      rd_next = 32'h0000_0000;
        endcase
    end

    // Read data register.
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
            AVS_READDATA_O <= 32'h0000_0000;
        else if (CE_I && AVS_READ_I && !ack)
            AVS_READDATA_O <= rd_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    sequence soft_s;
        CE_I && soft_rst;
    endsequence

    sequence rel_step_s;
        CE_I && step_now[0] && kind[0] == FDX_RELSEEK;
    endsequence

    one_relseek_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I) $countones(act & rel_mask()) <= 1)
        else $error("two relative seeks active");
    rel_dir_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        c_ok && c_drv == 2'h0 && c_kind == FDX_RELSEEK |=> DIR_O[0] == $past(AVS_WRITEDATA_I[`FDX_CMD_DIR]))
        else $error("relative step direction wrong");
    pc_wrap_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        rel_step_s ##0 $past(CE_I) |-> pc[0] == (dirr[0] ? $past(pc[0]) + 8'h01 : $past(pc[0]) - 8'h01))
        else $error("present cylinder not wrapped");
    track_fault_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        CE_I && act[0] && kind[0] == FDX_RELSEEK && tmr[0] == 16'h0 && !dirr[0] && h2[0] && cnt[0] != 8'h0
        |=> st0[`FDX_ST0_FAULT] && !act[0] && end_pend)
        else $error("track fault not flagged");
    recal_max_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        CE_I && act[3] && kind[3] == FDX_RECAL && tmr[3] == 16'h0 && !h2[3] && cnt[3] == `FDX_RECAL_MAX
        |=> !act[3] && st0[`FDX_ST0_FAULT] && st0[1:0] == 2'h3)
        else $error("recalibrate overran");
    hard_reset_a: assert property (@(posedge CLK_I) !RST_B_I |=> {gap, write_timing_select, pflags, lock} == 7'h0 && qdis)
        else $error("hardware reset incomplete");
    soft_perp_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I) soft_s |=> !gap && !write_timing_select && $stable(pflags))
        else $error("software reset perpendicular wrong");
    lock_keep_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I) soft_s ##0 lock |=> $stable({qdis, thr, pre}))
        else $error("locked settings changed");
    gap_len_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
        gap && write_timing_select |-> gap2_len == `FDX_GAP2_1M && vco_at == `FDX_VCO_1M && wg_bytes == `FDX_WG_1M)
        else $error("1 Mbps perpendicular timing wrong");
endmodule : fdx_core

//--- testbench/fdx_drive_model.sv
// Behavioural model of four floppy drive mechanisms on the far side of the step interface.
// Assumes step pulses and direction come from the block under test on the same clock.
`timescale 1ns/10ps
module fdx_drive_model (
    // Clock.
    input  wire logic       clk_i,
    // Drive pins from the block.
    input  wire logic [3:0] step_i,
    input  wire logic [3:0] dir_i,
    // Home sense back to the block.
    output logic      [3:0] home_o
);
    int          track [4] = '{0, 0, 0, 0};
    logic  [3:0] step_q    = 4'h0;

    // Each rising step edge moves a head one track; a head cannot pass below track zero.
    always @(posedge clk_i)
    begin
        step_q <= step_i;
        for (int i = 0; i < 4; i++)
            if (step_i[i] && !step_q[i])
                track[i] <= dir_i[i] ? track[i] + 1 : (track[i] > 0 ? track[i] - 1 : 0);
    end

    // Home sense is high only while a head sits on track zero.
    always_comb
        for (int j = 0; j < 4; j++)
            home_o[j] = (track[j] == 0);
endmodule : fdx_drive_model

//--- testbench/tb.sv
// Self-checking bench of the seek, perpendicular and lock block with a drive model.
// Assumes the register map of the block's configuration header; step timing of 5 and 1 cycles is set here.
`timescale 1ns/10ps
`include "fdx_cfg.svh"
`define CHK(g, e) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("wrong value at %0t: got %h expected %h", $time, g, e); \
        end \
    end
module tb;
    import fdx_pkg::*;
    typedef struct {logic [31:0] v; logic [31:0] m;} fdx_note_s;
    logic         clk   = 1'b0;
    logic         rst_b = 1'b0;
    logic         ce    = 1'b1;
    logic  [5:0]  adr   = 6'h00;
    logic         rd    = 1'b0;
    logic         wr    = 1'b0;
    logic  [31:0] wdat  = 32'h0;
    logic  [31:0] rdat;
    logic         wreq;
    logic  [3:0]  home;
    logic  [3:0]  step;
    logic  [3:0]  dir;
    fdx_regmode_e mode;
    fdx_note_s    notes [$];
    fdx_note_s    nt;
    int           mismatches = 0;
    int           n_tests    = 0;
    logic  [31:0] seed       = 32'hFA1D352B;
    logic  [31:0] last;
    logic  [31:0] cv;
    logic  [23:0] tim [4]    = '{24'h001816, 24'h131816, 24'h001816, 24'h262B29};
    logic  [2:0]  mv  [3]    = '{3'h0, 3'h2, 3'h6};
    fdx_regmode_e me  [3]    = '{FDX_COMPAT_A, FDX_COMPAT_B, FDX_COMPAT_C};

    // Clock of 100 ns period.
    always #50 clk = ~clk;

    fdx_core #(.STEP_CYC(5), .PULSE_CYC(1)) dut (
        .CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
        .HOME_TRACK_SENSE_I(home), .STEP_O(step), .DIR_O(dir), .REG_MODE_O(mode));
    fdx_drive_model dm (.clk_i(clk), .step_i(step), .dir_i(dir), .home_o(home));

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // Xorshift generator of the bench.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // One Avalon cycle held until waitrequest is seen low; reads leave a note for the monitor.
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge clk);
        if (!w)
            notes.push_back('{d, m});
        adr  <= a;
        rd   <= !w;
        wr   <= w;
        wdat <= w ? d : 32'h0;
        do
        begin
            @(posedge clk);
        end
        while (wreq !== 1'b0);
        last = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic rdx(input logic [5:0] a, input logic [31:0] v, input logic [31:0] m);
        bus(1'b0, a, v, m);
    endtask : rdx

    task automatic wrx(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0);
    endtask : wrx

    task automatic cmd(input logic [1:0] kind, input logic [1:0] drv, input logic dr, input logic [7:0] cnt);
        wrx(`FDX_A_CMD, {18'h0, kind, drv, 1'b0, dr, cnt});
    endtask : cmd

    // Polls the busy bits until every drive engine is idle.
    task automatic idle();
        do
        begin
            rdx(`FDX_A_CMD, 32'h0, 32'h0);
        end
        while (last[3:0] !== 4'h0);
    endtask : idle

    // Hardware reset held for five clock cycles.
    task automatic hrst();
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
    endtask : hrst

    // Monitor: each completed read takes the oldest note and compares the masked data.
    always @(posedge clk)
        if (rd && wreq === 1'b0 && notes.size() > 0)
        begin
            nt = notes.pop_front();
            if (nt.m !== 32'h0)
                `CHK(rdat & nt.m, nt.v & nt.m)
        end

    // Watchdog that cuts a hang short.
    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        close_out();
    end

    // Main sequence.
    initial
    begin
        hrst();
        rdx(`FDX_A_DUMP8, 32'h0, 32'hBF);
        rdx(`FDX_A_CONF, 32'h1, 32'hFFFF);
        for (int i = 0; i < 4; i++)
        begin
            wrx(`FDX_A_PERP, {30'h0, i[1:0]});
            rdx(`FDX_A_TIME, {8'h0, tim[i]}, 32'h00FFFFFF);
        end
        // Per-drive flags, write permit and their priority below the global bits.
        wrx(`FDX_A_PERP, 32'h3C);
        rdx(`FDX_A_DUMP8, 32'h0, 32'h3C);
        wrx(`FDX_A_PERP, 32'h84);
        wrx(`FDX_A_CONF, 32'h10001);
        rdx(`FDX_A_TIME, 32'h00260029, 32'h01FF00FF);
        wrx(`FDX_A_CONF, 32'h20001);
        rdx(`FDX_A_TIME, 32'h01001816, 32'h01FFFFFF);
        wrx(`FDX_A_CONF, 32'h10001);
        wrx(`FDX_A_PERP, 32'h01);
        rdx(`FDX_A_TIME, 32'h00130016, 32'h00FF00FF);
        // Software reset unlocked, lock result, software reset locked, hardware reset.
        cv = rnd() & 32'h0000FF1E;
        wrx(`FDX_A_CONF, cv);
        wrx(`FDX_A_SRST, 32'h0);
        rdx(`FDX_A_CONF, 32'h1, 32'hFFFF);
        rdx(`FDX_A_DUMP8, 32'h04, 32'hBF);
        wrx(`FDX_A_LOCK, 32'h80);
        rdx(`FDX_A_LOCK, 32'h10, 32'h10);
        wrx(`FDX_A_CONF, cv);
        wrx(`FDX_A_SRST, 32'h0);
        rdx(`FDX_A_CONF, cv, 32'hFFFF);
        rdx(`FDX_A_DUMP8, 32'h84, 32'hBF);
        hrst();
        rdx(`FDX_A_DUMP8, 32'h0, 32'hBF);
        rdx(`FDX_A_CONF, 32'h1, 32'hFFFF);
        wrx(6'h3C, 32'hFFFFFFFF);
        rdx(6'h3C, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 3; i++)
        begin
            wrx(`FDX_A_MODE, {29'h0, mv[i]});
            @(posedge clk);
            `CHK(mode, me[i])
        end
        // Relative seeks inward, across track 255, outward and past track zero.
        cmd(2'h1, 2'h0, 1'b1, 8'h05);
        idle();
        `CHK(dm.track[0], 5)
        rdx(`FDX_A_STAT, 32'h10520, 32'h1FFFF);
        cmd(2'h1, 2'h0, 1'b1, 8'hFE);
        idle();
        `CHK(dm.track[0], 259)
        rdx(`FDX_A_STAT, 32'h0320, 32'hFFFF);
        cmd(2'h1, 2'h0, 1'b0, 8'hFF);
        idle();
        `CHK(dm.track[0], 4)
        cmd(2'h1, 2'h0, 1'b0, 8'h0A);
        idle();
        rdx(`FDX_A_STAT, 32'h70, 32'hF3);
        // One relative seek at a time, overlapped with an ordinary seek.
        cmd(2'h1, 2'h0, 1'b1, 8'h14);
        cmd(2'h1, 2'h1, 1'b1, 8'h03);
        cmd(2'h0, 2'h2, 1'b0, 8'h09);
        rdx(`FDX_A_CMD, 32'h5, 32'hF);
        // Clock enable low freezes the engines: no step reaches the drive meanwhile.
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        cv = dm.track[0];
        repeat (20) @(posedge clk);
        `CHK(dm.track[0], cv)
        ce <= 1'b1;
        idle();
        `CHK(dm.track[1], 0)
        `CHK(dm.track[2], 9)
        // Recalibrate from track 85 stops after 80 steps with an error, then completes.
        cmd(2'h1, 2'h3, 1'b1, 8'h55);
        idle();
        cmd(2'h2, 2'h3, 1'b0, 8'h00);
        idle();
        `CHK(dm.track[3], 5)
        rdx(`FDX_A_STAT, 32'h30, 32'h30);
        cmd(2'h2, 2'h3, 1'b0, 8'h00);
        idle();
        `CHK(dm.track[3], 0)
        rdx(`FDX_A_STAT, 32'h20, 32'hFF30);
        close_out();
    end
endmodule : tb
